/* File: src/time_base_tick_timer.sv */
// Behaviour
// - enable bit3, rate bits2-0, upper bits zero
// - enabled ticks on tap falling edge only
// - gear taps 2^22,20,15,13,12,11,10,8
// - low-clock taps; 111 reserved; slow allows 000/001
// - stop entry clears enable, keeps rate
// - prescaler runs regardless of enable
// - first tick at next tap fall
// - low-clock sync in normal mode jitters ticks
module time_base_tick_timer #(
  parameter int SCALE_SHIFT = 0  // shortens every tap for simulation
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic LOW_CLK_IN,
  input wire tick_timer_pkg::mode_e MODE_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic TICK_REQ_OUT,
  output logic IRQ_OUT
);
  import tick_timer_pkg::*;

  localparam int GEAR_W = GEAR_DIV_W - SCALE_SHIFT;
  localparam int LOW_W = LOW_DIV_W - SCALE_SHIFT;
  localparam int FIRST_TICK_MAX = 257;

  // tap bit index for a rate code, after simulation shortening
  function automatic int tap_index(input logic use_low,
                                   input logic [2:0] code);
    int e;
    e = use_low ? LOW_EXP[code] : GEAR_EXP[code];
    e = e - SCALE_SHIFT;
    if (e < 1) begin
      e = 1;
    end
    return e - 1;
  endfunction : tap_index

  // whether a rate code is usable in the current clocking
  function automatic logic rate_valid(input logic use_low,
                                      input logic slow,
                                      input logic [2:0] code);
    if (!use_low) begin
      return 1'b1;
    end else if (slow) begin
      return code <= RATE_SLOW_MAX;
    end else begin
      return code != RATE_FASTEST;
    end
  endfunction : rate_valid

  // register state
  ctrl_s ctrl;             // tick timer control
  logic div_sel;           // divider low clock select
  logic status;            // sticky tick event
  logic mask;              // interrupt mask
  mode_e mode_q;           // last mode, for stop entry detection

  // bus data-phase state
  logic wr_pend;           // write data phase pending
  logic rd_pend;           // read wait state pending
  logic [WORD_IDX_W-1:0] dp_idx;  // word index of the data phase
  logic dp_in_range;       // upper address bits were zero

  // prescalers and tap
  logic low_q;             // low clock level one cycle ago
  logic low_rise;          // low clock rising edge, one cycle
  logic [GEAR_W-1:0] gear_count;
  logic [LOW_W-1:0] low_count;
  logic slow_mode;         // gear clock taken from low clock
  logic use_low;           // low clock feeds the prescaler
  logic tap_now;           // selected tap level this cycle
  logic tap_q;             // selected tap level last cycle
  logic tap_fall;          // selected tap just fell
  logic code_ok;           // rate code usable now
  logic tick_fire;         // request to be issued
  logic stop_entry;        // stop mode just entered
  logic accept;            // address phase taken
  logic rd_ctrl;           // read of control in progress
  logic rd_status;         // read of status in progress
  logic [31:0] rd_value;   // read mux result
  logic next_status;       // status after set and clear

  // low clock is synchronous here; normal-mode edges still land on
  // gear cycles, so tick spacing wobbles by a cycle
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      low_q <= 1'b0;
    end else begin
      low_q <= LOW_CLK_IN;
    end
  end

  assign low_rise = LOW_CLK_IN & ~low_q;

  // gear-clock prescaler, never gated by the enable
  tick_prescaler #(
    .WIDTH(GEAR_W)
  ) u_gear_div (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .step_in(1'b1),
    .count_out(gear_count)
  );

  // low-clock prescaler, advanced on each low clock rising edge
  tick_prescaler #(
    .WIDTH(LOW_W)
  ) u_low_div (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .step_in(low_rise),
    .count_out(low_count)
  );

  // clock source selection from mode and divider select
  assign slow_mode = (MODE_IN == MODE_SLOW) || (MODE_IN == MODE_SLEEP);
  assign use_low = slow_mode || div_sel;
  assign code_ok = rate_valid(use_low, slow_mode, ctrl.rate);

  // tap multiplexer; changing the rate mid-run can fake an edge,
  // which is why software must hold the enable low meanwhile
  always_comb begin
    if (use_low) begin
      tap_now = low_count[tap_index(1'b1, ctrl.rate)];
    end else begin
      tap_now = gear_count[tap_index(1'b0, ctrl.rate)];
    end
  end

  // tap history for falling edge detection
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      tap_q <= 1'b0;
    end else begin
      tap_q <= tap_now;
    end
  end

  assign tap_fall = tap_q & ~tap_now;
  // first fall after enabling fires, so first gap may be short
  assign tick_fire = tap_fall & ctrl.enable & code_ok;

  // tick request pulse toward the interrupt controller
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      TICK_REQ_OUT <= 1'b0;
    end else begin
      TICK_REQ_OUT <= tick_fire;
    end
  end

  // mode history; stop entry is a one-cycle event
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      mode_q <= MODE_NORMAL;
    end else begin
      mode_q <= MODE_IN;
    end
  end

  assign stop_entry = (MODE_IN == MODE_STOP) && (mode_q != MODE_STOP);

  // ahb address phase acceptance
  assign accept = HSEL_IN && HREADY_IN && (HTRANS_IN == HTRANS_NONSEQ)
                  && (HSIZE_IN == HSIZE_WORD);

  // data-phase bookkeeping; reads take one wait state so that
  // read data can leave a flip-flop
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      dp_idx <= '0;
      dp_in_range <= 1'b0;
    end else begin
      wr_pend <= accept && HWRITE_IN;
      rd_pend <= accept && !HWRITE_IN;
      if (accept) begin
        dp_idx <= HADDR_IN[WORD_IDX_W+1:2];
        dp_in_range <= (HADDR_IN[31:WORD_IDX_W+2] == '0);
      end
    end
  end

  // ready drops for the read wait state only
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      HREADYOUT_OUT <= 1'b1;
    end else begin
      HREADYOUT_OUT <= !(accept && !HWRITE_IN);
    end
  end

  // error responses are never given
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      HRESP_OUT <= HRESP_OKAY;
    end else begin
      HRESP_OUT <= HRESP_OKAY;
    end
  end

  // control register; stop entry wins over a same-cycle write
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      ctrl <= CONTROL_RESET;
    end else if (stop_entry) begin
      ctrl.enable <= 1'b0;
    end else if (wr_pend && dp_in_range && dp_idx == IDX_CONTROL) begin
      ctrl.enable <= HWDATA_IN[EN_BIT];
      ctrl.rate <= HWDATA_IN[RATE_LSB +: RATE_W];
    end
  end

  // divider select and interrupt mask
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      div_sel <= CONFIG_RESET;
      mask <= MASK_RESET;
    end else if (wr_pend && dp_in_range) begin
      if (dp_idx == IDX_CONFIG) begin
        div_sel <= HWDATA_IN[DIVSEL_BIT];
      end
      if (dp_idx == IDX_MASK) begin
        mask <= HWDATA_IN[TICK_EV_BIT];
      end
    end
  end

  assign rd_ctrl = rd_pend && dp_in_range && dp_idx == IDX_CONTROL;
  assign rd_status = rd_pend && dp_in_range && dp_idx == IDX_STATUS;

  // sticky tick event; a tick in the clearing read's cycle survives
  always_comb begin
    next_status = status;
    if (rd_status) begin
      next_status = 1'b0;
    end
    if (tick_fire) begin
      next_status = 1'b1;
    end
  end

  // status register
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      status <= STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= next_status & mask;
    end
  end

  // read multiplexer; unmapped words read zero
  always_comb begin
    rd_value = '0;
    if (dp_in_range) begin
      unique case (dp_idx)
        IDX_CONTROL: begin
          rd_value[EN_BIT] = ctrl.enable;
          rd_value[RATE_LSB +: RATE_W] = ctrl.rate;
        end
        IDX_CONFIG: rd_value[DIVSEL_BIT] = div_sel;
        IDX_STATUS: rd_value[TICK_EV_BIT] = status;
        IDX_MASK: rd_value[TICK_EV_BIT] = mask;
        default: rd_value = '0;
      endcase
    end
  end

  // read data register, loaded in the wait state
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      HRDATA_OUT <= '0;
    end else if (rd_pend) begin
      HRDATA_OUT <= rd_value;
    end
  end

  // ---- checks ----

  sequence stop_enter_s;
    (MODE_IN == MODE_STOP) && (mode_q != MODE_STOP);
  endsequence

  sequence enable_rise_s;
    $rose(ctrl.enable) && !use_low && ctrl.rate == RATE_FASTEST;
  endsequence

  ctrl_read_zero_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    rd_ctrl |=> (HRDATA_OUT[31:EN_BIT+1] == '0)
      && HRDATA_OUT[EN_BIT] == $past(ctrl.enable))
    else $error("control read shows wrong bits");

  tick_needs_enable_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    TICK_REQ_OUT |-> $past(ctrl.enable) && $past(tap_q) && !$past(tap_now))
    else $error("tick without enable or tap fall");

  gear_fast_tap_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    (!use_low && ctrl.rate == RATE_FASTEST && ctrl.enable
      && gear_count[tap_index(1'b0, RATE_FASTEST)] == 1'b0
      && $past(gear_count[tap_index(1'b0, RATE_FASTEST)]))
    |=> TICK_REQ_OUT)
    else $error("fastest gear tap fall gave no tick");

  reserved_quiet_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    (use_low && (ctrl.rate == RATE_FASTEST
      || (slow_mode && ctrl.rate > RATE_SLOW_MAX)))
    |=> !TICK_REQ_OUT)
    else $error("tick on reserved rate code");

  stop_clears_en_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    stop_enter_s |=> !ctrl.enable && ctrl.rate == $past(ctrl.rate))
    else $error("stop entry left enable set or moved rate");

  prescale_free_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    !RST_IN && !ctrl.enable ##1 !ctrl.enable |->
      gear_count == GEAR_W'($past(gear_count) + 1'b1))
    else $error("gear prescaler stalled while disabled");

  first_tick_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    enable_rise_s |-> ##[1:FIRST_TICK_MAX]
      (TICK_REQ_OUT || !ctrl.enable || use_low))
    else $error("first tick late after enabling");

  tick_single_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    TICK_REQ_OUT |=> !TICK_REQ_OUT)
    else $error("tick request longer than one cycle");

  irq_follows_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    TICK_REQ_OUT && $past(mask) |-> IRQ_OUT)
    else $error("unmasked tick did not raise interrupt");

endmodule : time_base_tick_timer

/* File: include/tick_timer_pkg.sv */
package tick_timer_pkg;

  // operating modes reported by the system controller
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_IDLE,
    MODE_SLOW,
    MODE_SLEEP,
    MODE_STOP
  } mode_e;

  // fields of the tick timer control register
  typedef struct packed {
    logic enable;      // request enable
    logic [2:0] rate;  // rate select
  } ctrl_s;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h39;
  localparam logic [7:0] IDX_CONFIG = 8'h3a;
  localparam logic [7:0] IDX_STATUS = 8'h3b;
  localparam logic [7:0] IDX_MASK = 8'h3c;

  // control register layout and reset values
  localparam int EN_BIT = 3;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 3;
  localparam logic [3:0] CONTROL_RESET = 4'h0;
  localparam logic CONFIG_RESET = 1'b0;
  localparam logic STATUS_RESET = 1'b0;
  localparam logic MASK_RESET = 1'b0;

  // config, status and mask bit positions
  localparam int DIVSEL_BIT = 0;
  localparam int TICK_EV_BIT = 0;

  // prescaler widths and tap exponents per rate code
  localparam int GEAR_DIV_W = 22;
  localparam int LOW_DIV_W = 15;
  localparam int GEAR_EXP [8] = '{22, 20, 15, 13, 12, 11, 10, 8};
  // zero marks a reserved code
  localparam int LOW_EXP [8] = '{15, 13, 8, 6, 5, 4, 3, 0};
  localparam logic [2:0] RATE_SLOW_MAX = 3'h1;
  localparam logic [2:0] RATE_FASTEST = 3'h7;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam int WORD_IDX_W = 8;

endpackage : tick_timer_pkg

/* File: src/tick_prescaler.sv */
// free-running binary divider; each bit k toggles at step/2^(k+1)
module tick_prescaler #(
  parameter int WIDTH = 22
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic step_in,
  output logic [WIDTH-1:0] count_out
);

  // counter advances on every step, never gated by anything else
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_out <= '0;
    end else if (step_in) begin
      count_out <= WIDTH'(count_out + 1'b1);
    end
  end

endmodule : tick_prescaler

/* File: tb/tick_irq_sink.sv */
// interrupt controller side: counts tick requests, flags stretched ones
module tick_irq_sink (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  output int pulse_count_out,
  output logic long_pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tick_q; // request seen last cycle
  // a request high two cycles running would be taken twice
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_q <= 1'b0;
      pulse_count_out <= 0;
      long_pulse_out <= 1'b0;
    end else begin
      tick_q <= tick_in;
      if (tick_in && !tick_q) pulse_count_out <= pulse_count_out + 1;
      if (tick_in && tick_q) long_pulse_out <= 1'b1;
    end
  end
endmodule : tick_irq_sink

/* File: tb/time_base_tick_timer_tb.sv */
module time_base_tick_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tick_timer_pkg::*;
  localparam int SHIFT = 7; // shortens taps; gear code 7 ticks every 2
  logic clk = 0, rst = 1, low_clk = 0, hsel = 0, hwrite = 0, rd_phase = 0;
  mode_e mode = MODE_NORMAL;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hrdata;
  logic hready, hresp, tick, irq, long_pulse;
  int err_count = 0, cmp_count = 0, pulses, n, p, c;
  time t0;
  logic [31:0] exp_q[$]; // expected read data, oldest first
  always #5 clk = ~clk;
  // low clock toggles on falling edges, every two cycles
  always #20 low_clk = ~low_clk;
  time_base_tick_timer #(.SCALE_SHIFT(SHIFT)) dut (.REF_CLK_IN(clk),
    .RST_IN(rst), .LOW_CLK_IN(low_clk), .MODE_IN(mode), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .TICK_REQ_OUT(tick), .IRQ_OUT(irq));
  tick_irq_sink sink (.clk_in(clk), .rst_in(rst), .tick_in(tick),
    .pulse_count_out(pulses), .long_pulse_out(long_pulse));
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // read data phase ends: take the oldest note and compare
  always @(posedge clk) begin
    if (rd_phase && hready === 1'b1) begin
      chk(hrdata, exp_q.pop_front());
      chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
    end
  end
  // bounded wait for hready sampled high; a hang ends the run
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) begin
      err_count++;
      summarize();
    end
  endtask : wait_rdy
  // one word transfer; d is write data or the expected read data
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    rd_phase <= !wr;
    if (!wr) exp_q.push_back(d);
    wait_rdy();
    rd_phase <= 1'b0;
  endtask : bus
  // cycles until the next request, bounded by lim
  task automatic wait_tick(input int lim, output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (tick !== 1'b1 && k < lim);
    if (tick !== 1'b1) begin
      err_count++;
      summarize();
    end
  endtask : wait_tick
  // no request may appear for lim cycles; two cycles let stragglers pass
  task automatic quiet(input int lim);
    int seen;
    seen = 0;
    repeat (2) @(posedge clk);
    repeat (lim) begin
      @(posedge clk);
      if (tick === 1'b1) seen++;
    end
    chk(32'(seen), 32'h0);
  endtask : quiet
  initial begin
    void'($urandom(83));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(0, IDX_CONTROL, 32'h0);
    bus(0, IDX_STATUS, 32'h0);
    bus(1, IDX_CONTROL, 32'hffff_fff7);
    bus(0, IDX_CONTROL, 32'h7);
    bus(1, 8'h20, $urandom);
    bus(0, 8'h20, 32'h0);
    $display("test registers done");
    // every gear code but the slowest; idle on odd codes
    for (c = 7; c >= 1; c--) begin
      p = 1 << (GEAR_EXP[c] - SHIFT);
      mode <= c[0] ? MODE_IDLE : MODE_NORMAL;
      bus(1, IDX_CONTROL, 32'(c));
      bus(1, IDX_CONTROL, 32'(8 | c));
      wait_tick(p + 8, n);
      // a fall on the enabling edge is seen two edges on, the latest
      // one a full period plus the request register later
      chk(32'(n >= 2 && n <= p + 1), 32'h1);
      wait_tick(p + 8, n);
      chk(32'(n), 32'(p));
      bus(1, IDX_CONTROL, 32'(c));
      quiet(300);
    end
    $display("test gear rates done");
    // pause mid-period: prescaler keeps phase while disabled
    c = 2 + $urandom % 4;
    p = 1 << (GEAR_EXP[c] - SHIFT);
    // new rate goes in while disabled, or the tap swap fakes a fall
    bus(1, IDX_CONTROL, 32'(c));
    bus(1, IDX_CONTROL, 32'(8 | c));
    wait_tick(p + 8, n);
    t0 = $time;
    bus(1, IDX_CONTROL, 32'(c));
    bus(1, IDX_CONTROL, 32'(8 | c));
    wait_tick(p + 8, n);
    chk(32'(($time - t0) / 10), 32'(p));
    mode <= MODE_STOP;
    repeat (2) @(posedge clk);
    mode <= MODE_NORMAL;
    bus(0, IDX_CONTROL, 32'(c));
    quiet(100);
    $display("test stop entry done");
    // masked event, then unmasked; earlier ticks left the status set
    bus(0, IDX_STATUS, 32'h1);
    bus(1, IDX_CONTROL, 32'h6);
    bus(1, IDX_CONTROL, 32'he);
    wait_tick(20, n);
    bus(1, IDX_CONTROL, 32'h6);
    chk({31'h0, irq}, 32'h0);
    bus(0, IDX_STATUS, 32'h1);
    bus(0, IDX_STATUS, 32'h0);
    bus(1, IDX_MASK, 32'h1);
    bus(0, IDX_MASK, 32'h1);
    bus(1, IDX_CONTROL, 32'he);
    wait_tick(20, n);
    chk({31'h0, irq}, 32'h1);
    bus(1, IDX_CONTROL, 32'h6);
    bus(0, IDX_STATUS, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    // low clock source: sleep then slow, four cycles per step
    for (c = 0; c <= 1; c++) begin
      p = 4 << (LOW_EXP[c] - SHIFT);
      mode <= c ? MODE_SLOW : MODE_SLEEP;
      bus(1, IDX_CONTROL, 32'(c));
      bus(1, IDX_CONTROL, 32'(8 | c));
      wait_tick(p + 8, n);
      wait_tick(p + 8, n);
      chk(32'(n), 32'(p));
      bus(1, IDX_CONTROL, 32'(c));
    end
    bus(1, IDX_CONTROL, 32'ha);
    quiet(300);
    bus(1, IDX_CONTROL, 32'h1);
    mode <= MODE_NORMAL;
    bus(1, IDX_CONFIG, 32'h1);
    bus(1, IDX_CONTROL, 32'h9);
    wait_tick(300, n);
    wait_tick(300, n);
    chk(32'(n >= 248 && n <= 264), 32'h1);
    bus(1, IDX_CONTROL, 32'h1);
    // code 7 is reserved on the low clock even in normal mode
    bus(1, IDX_CONTROL, 32'h7);
    bus(1, IDX_CONTROL, 32'hf);
    quiet(300);
    bus(1, IDX_CONTROL, 32'h7);
    chk({31'h0, long_pulse}, 32'h0);
    chk(32'(pulses > 10), 32'h1);
    $display("test low clock done");
    summarize();
  end
endmodule : time_base_tick_timer_tb
